// ==== src/tac_pkg.sv ====
package tac_pkg;

    // ==========================================================
    // Register map (byte addresses on the register bus)
    // ==========================================================
    localparam int unsigned TAC_AW            = 8;
    localparam int unsigned TAC_DW            = 32;
    localparam logic [7:0]  TAC_OFF_CONFIG    = 8'h00;
    localparam logic [7:0]  TAC_OFF_TARGET    = 8'h04;
    localparam logic [7:0]  TAC_OFF_DATA_CMD  = 8'h10;
    localparam logic [7:0]  TAC_OFF_CLR_ALL   = 8'h40;
    localparam logic [7:0]  TAC_OFF_CLR_ABORT = 8'h54;
    localparam logic [7:0]  TAC_OFF_ENABLE    = 8'h6c;
    localparam logic [7:0]  TAC_OFF_CAUSE     = 8'h80;
    localparam logic [7:0]  TAC_OFF_IRQ_STAT  = 8'h84;
    localparam logic [7:0]  TAC_OFF_IRQ_MASK  = 8'h88;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int unsigned TAC_RESTART_EN_BIT = 5;
    localparam int unsigned TAC_CMD_SEL_A_BIT  = 11;
    localparam int unsigned TAC_GC_START_BIT   = 10;
    localparam int unsigned TAC_CMD_READ_BIT   = 8;
    localparam int unsigned TAC_ENABLE_BIT     = 0;
    localparam int unsigned TAC_ABORT_REQ_BIT  = 1;
    localparam int unsigned TAC_SW_ABORT_BIT   = 16;
    localparam int unsigned TAC_SLVRD_BIT      = 15;
    localparam int unsigned TAC_SLV_LOST_BIT   = 14;
    localparam int unsigned TAC_SLV_FLUSH_BIT  = 13;
    localparam int unsigned TAC_ARBITRATION_LOST_CAUSE_BIT   = 12;
    localparam int unsigned TAC_SBYTE_BIT      = 9;
    localparam int unsigned TAC_IRQ_ABORT_BIT  = 0;

    // ==========================================================
    // Widths and reset values
    // ==========================================================
    localparam int unsigned TAC_CAUSE_W = 17;
    localparam int unsigned TAC_RSVD_W  = 6;
    localparam int unsigned TAC_CNT_W   = 9;
    localparam int unsigned TAC_LVL_W   = 5;
    localparam int unsigned TAC_IRQ_W   = 1;
    localparam logic [TAC_CAUSE_W-1:0] TAC_CAUSE_RST = 17'h00000;
    localparam logic [TAC_CNT_W-1:0]   TAC_CNT_RST   = 9'h000;
    localparam logic [TAC_RSVD_W-1:0]  TAC_RSVD_VAL  = 6'h00;
    localparam logic [TAC_IRQ_W-1:0]   TAC_IRQ_RST   = 1'h0;
    localparam logic [TAC_DW-1:0]      TAC_ZERO_WORD = 32'h0000_0000;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [0:0] {
        TAC_BUS_IDLE = 1'b0,
        TAC_BUS_ACK  = 1'b1
    } tac_bus_state_t;

    typedef struct packed {
        logic [TAC_AW-1:0] address;
        logic              read;
        logic              write;
        logic [TAC_DW-1:0] writedata;
    } tac_avl_req_t;

    typedef struct packed {
        logic                 master_tx;
        logic                 slave_tx;
        logic                 slave_rd_req;
        logic                 slave_read_cmd;
        logic                 master_arbitration_lost_cause;
        logic                 sbyte_attempt;
        logic [TAC_LVL_W-1:0] tx_fifo_level;
    } tac_core_ev_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic tx_bit;
    } tac_pins_t;

    typedef struct packed {
        tac_bus_state_t state;
    } tac_bus_s_t;

    typedef struct packed {
        logic scl_prev;
        logic lost;
    } tac_loss_s_t;

    typedef struct packed {
        logic                   restart_en;
        logic                   cmd_sel_a;
        logic                   gc_start;
        logic                   enable;
        logic                   abort_req;
        logic [TAC_CAUSE_W-1:0] cause;
        logic [TAC_CNT_W-1:0]   flush_cnt;
        logic                   sbyte_pend;
        logic [TAC_IRQ_W-1:0]   stat;
        logic [TAC_IRQ_W-1:0]   mask;
        logic [TAC_CAUSE_W-1:0] snap_cause;
        logic [TAC_IRQ_W-1:0]   snap_stat;
        logic [TAC_DW-1:0]      readdata;
        logic                   abort_evt;
    } tac_top_s_t;

endpackage

// ==== src/tac_bus_slave.sv ====
module tac_bus_slave (
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          rst,
    // Bus request
    input  tac_pkg::tac_avl_req_t req,
    // Handshake
    output logic               waitrequest,
    output logic               capture,
    output logic               take
);
    import tac_pkg::*;

    tac_bus_s_t s_r;
    tac_bus_s_t s_nxt;

    // ==========================================================
    // One wait state per access
    // ==========================================================
    // The wait state lets read data come from a flop without a combinational path.
    always_comb begin
        s_nxt = s_r;
        case (s_r.state)
            TAC_BUS_IDLE: begin
                if (req.read || req.write) begin
                    s_nxt.state = TAC_BUS_ACK;
                end
            end
            TAC_BUS_ACK: begin
                s_nxt.state = TAC_BUS_IDLE;
            end
            default: begin
                s_nxt.state = TAC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_r.state <= TAC_BUS_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign capture     = (s_r.state == TAC_BUS_IDLE) && (req.read || req.write);
    assign waitrequest = capture;
    assign take        = (s_r.state == TAC_BUS_ACK) && (req.read || req.write);

    chk_bus_one_wait: assert property (@(posedge mclk) disable iff (rst)
        capture |=> (!waitrequest && (s_r.state == TAC_BUS_ACK)))
        else $error("bus access did not complete after one wait state");

endmodule

// ==== src/tac_loss_detect.sv ====
module tac_loss_detect (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // Line sampling
    input  tac_pkg::tac_pins_t pins,
    input  wire logic         active,
    // Result
    output logic              lost
);
    import tac_pkg::*;

    tac_loss_s_t s_r;
    tac_loss_s_t s_nxt;

    // ==========================================================
    // Data line check at each rising clock line edge
    // ==========================================================
    always_comb begin
        s_nxt          = s_r;
        s_nxt.scl_prev = pins.scl;
        s_nxt.lost     = active && pins.scl && !s_r.scl_prev
                         && (pins.sda != pins.tx_bit); // see [R10]
    end

    // The clock line idles high, so the edge memory starts high; a low start would
    // report a false rise on the first edge after reset.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_r <= '{scl_prev: 1'b1, lost: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign lost = s_r.lost;

    chk_loss_on_edge: assert property (@(posedge mclk) disable iff (rst) // see [R10]
        (active && pins.scl && !s_r.scl_prev && (pins.sda != pins.tx_bit)) |=> lost)
        else $error("data line mismatch at clock rise not flagged");

    chk_loss_cause_only: assert property (@(posedge mclk) disable iff (rst) // see [R10]
        lost |-> $past(active && pins.scl && !s_r.scl_prev && (pins.sda != pins.tx_bit)))
        else $error("loss flagged without a mismatch");

endmodule

// ==== src/tac_abort_capture.sv ====
// Contract
// [R1] Reading abort-clear or all-interrupt-clear clears all cause bits but bit 9.
// [R2] Bit 9 clears only once restart enabled or either selector bit cleared.
// [R3] Clearing bit 9 while its source persists drops it one cycle, then sets.
// [R4] Bits 31:23 count transmit commands flushed by aborts.
// [R5] Flushed-command count is zeroed whenever the controller is disabled.
// [R6] Master transmitter sets bit 16 on a software abort request.
// [R7] Bit 15 set when a read command is written while serving a slave read.
// [R8] Bit 14 set when slave transmitter loses the data line.
// [R9] Bit 12 is set together with bit 14.
// [R10] Slave loss found by comparing data line at each clock line rise.
// [R11] Bit 12 flags master arbitration loss, or slave loss with bit 14.
// [R12] Bit 13 set, abort raised, when slave read meets stale transmit data.
// [R13] Cause register reads zero after reset; writes to it are ignored.
module tac_abort_capture (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // Register bus
    input  tac_pkg::tac_avl_req_t avs_req,
    output logic                  avs_waitrequest,
    output logic [31:0]           avs_readdata,
    // Controller core events
    input  tac_pkg::tac_core_ev_t core_ev,
    // Bus lines as sampled
    input  tac_pkg::tac_pins_t    line_pins,
    // Results
    output logic                  transmit_abort_event,
    output logic                  controller_enable,
    output logic                  irq
);
    import tac_pkg::*;

    tac_top_s_t s_r;
    tac_top_s_t s_nxt;

    logic                   capture;
    logic                   take;
    logic                   slv_lost;
    logic                   sbyte_src;
    logic                   clr_cause;
    logic                   clr_stat;
    logic                   data_cmd_rd;
    logic                   new_abort;
    logic [TAC_CAUSE_W-1:0] set_new;
    logic [TAC_CAUSE_W-1:0] set_all;
    logic [TAC_DW-1:0]      rd_word;

    // ==========================================================
    // Bus handshake and line checker
    // ==========================================================
    tac_bus_slave i_tac_bus_slave (
        .mclk        (mclk),
        .rst         (rst),
        .req         (avs_req),
        .waitrequest (avs_waitrequest),
        .capture     (capture),
        .take        (take)
    );

    tac_loss_detect i_tac_loss_detect (
        .mclk   (mclk),
        .rst    (rst),
        .pins   (line_pins),
        .active (core_ev.slave_tx),
        .lost   (slv_lost)
    );

    // ==========================================================
    // Event decode
    // ==========================================================
    // The start-byte fault persists while restarts are off and both selectors are on.
    assign sbyte_src = !s_r.restart_en && s_r.cmd_sel_a && s_r.gc_start; // see [R2]

    assign clr_cause = take && avs_req.read
                       && ((avs_req.address == TAC_OFF_CLR_ABORT)
                           || (avs_req.address == TAC_OFF_CLR_ALL)); // see [R1]
    assign clr_stat  = take && avs_req.read
                       && ((avs_req.address == TAC_OFF_IRQ_STAT)
                           || (avs_req.address == TAC_OFF_CLR_ALL));

    assign data_cmd_rd = take && avs_req.write && (avs_req.address == TAC_OFF_DATA_CMD)
                         && avs_req.writedata[TAC_CMD_READ_BIT];

    always_comb begin
        set_new                    = '0;
        set_new[TAC_SW_ABORT_BIT]  = s_r.abort_req && core_ev.master_tx; // see [R6]
        set_new[TAC_SLVRD_BIT]     = data_cmd_rd && core_ev.slave_rd_req; // see [R7]
        set_new[TAC_SLV_LOST_BIT]  = slv_lost; // see [R8]
        set_new[TAC_ARBITRATION_LOST_CAUSE_BIT]  = core_ev.master_arbitration_lost_cause || slv_lost; // see [R9] [R11]
        set_new[TAC_SLV_FLUSH_BIT] = core_ev.slave_read_cmd
                                     && (core_ev.tx_fifo_level != '0); // see [R12]
        set_new[TAC_SBYTE_BIT]     = core_ev.sbyte_attempt && sbyte_src;
        set_all                    = set_new;
        set_all[TAC_SBYTE_BIT]     = set_new[TAC_SBYTE_BIT] || s_r.sbyte_pend; // see [R3]
    end

    // A re-asserted start-byte bit is the same fault, so it raises no new abort.
    assign new_abort = |set_new;

    // ==========================================================
    // Read data
    // ==========================================================
    always_comb begin
        rd_word = TAC_ZERO_WORD;
        if (avs_req.address == TAC_OFF_CONFIG) begin
            rd_word[TAC_RESTART_EN_BIT] = s_r.restart_en;
        end else if (avs_req.address == TAC_OFF_TARGET) begin
            rd_word[TAC_CMD_SEL_A_BIT] = s_r.cmd_sel_a;
            rd_word[TAC_GC_START_BIT]  = s_r.gc_start;
        end else if (avs_req.address == TAC_OFF_ENABLE) begin
            rd_word[TAC_ENABLE_BIT]    = s_r.enable;
            rd_word[TAC_ABORT_REQ_BIT] = s_r.abort_req;
        end else if (avs_req.address == TAC_OFF_CAUSE) begin
            rd_word = {s_r.flush_cnt, TAC_RSVD_VAL, s_r.cause}; // see [R4] [R13]
        end else if (avs_req.address == TAC_OFF_IRQ_STAT) begin
            rd_word[TAC_IRQ_W-1:0] = s_r.stat;
        end else if (avs_req.address == TAC_OFF_IRQ_MASK) begin
            rd_word[TAC_IRQ_W-1:0] = s_r.mask;
        end else begin
            rd_word = TAC_ZERO_WORD;
        end
    end

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        s_nxt           = s_r;
        s_nxt.abort_evt = new_abort; // see [R12]

        // Snapshot at capture so a clear only removes what software actually saw.
        if (capture) begin
            s_nxt.snap_cause = s_r.cause;
            s_nxt.snap_stat  = s_r.stat;
            if (avs_req.read) begin
                s_nxt.readdata = rd_word;
            end
        end

        // Register writes; the cause register has no write path.
        if (take && avs_req.write) begin // see [R13]
            if (avs_req.address == TAC_OFF_CONFIG) begin
                s_nxt.restart_en = avs_req.writedata[TAC_RESTART_EN_BIT];
            end else if (avs_req.address == TAC_OFF_TARGET) begin
                s_nxt.cmd_sel_a = avs_req.writedata[TAC_CMD_SEL_A_BIT];
                s_nxt.gc_start  = avs_req.writedata[TAC_GC_START_BIT];
            end else if (avs_req.address == TAC_OFF_ENABLE) begin
                s_nxt.enable    = avs_req.writedata[TAC_ENABLE_BIT];
                s_nxt.abort_req = avs_req.writedata[TAC_ABORT_REQ_BIT];
            end else if (avs_req.address == TAC_OFF_IRQ_MASK) begin
                s_nxt.mask = avs_req.writedata[TAC_IRQ_W-1:0];
            end
        end

        // The abort request is consumed once the master transmitter acts on it.
        if (set_new[TAC_SW_ABORT_BIT] || !s_r.enable) begin // see [R6]
            s_nxt.abort_req = 1'b0;
        end

        // Set wins over clear for every cause bit.
        s_nxt.cause = (s_r.cause & ~(clr_cause ? s_r.snap_cause : TAC_CAUSE_RST))
                      | set_all; // see [R1]
        s_nxt.sbyte_pend = clr_cause && s_r.snap_cause[TAC_SBYTE_BIT]
                           && sbyte_src; // see [R2] [R3]

        if (!s_r.enable) begin
            s_nxt.flush_cnt = TAC_CNT_RST; // see [R5]
        end else if (new_abort) begin
            s_nxt.flush_cnt = TAC_CNT_W'(s_r.flush_cnt + core_ev.tx_fifo_level); // see [R4]
        end

        s_nxt.stat = (s_r.stat & ~(clr_stat ? s_r.snap_stat : TAC_IRQ_RST));
        s_nxt.stat[TAC_IRQ_ABORT_BIT] = s_nxt.stat[TAC_IRQ_ABORT_BIT] || new_abort;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_r <= '0; // see [R13]
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign avs_readdata         = s_r.readdata;
    assign transmit_abort_event = s_r.abort_evt;
    assign controller_enable    = s_r.enable;
    assign irq                  = |(s_r.stat & s_r.mask);

    // ==========================================================
    // Checks
    // ==========================================================
    chk_clear_all_but: assert property (@(posedge mclk) disable iff (rst) // see [R1]
        (clr_cause && !(|set_all)) |=>
            ((s_r.cause & ~(TAC_CAUSE_W'(1) << TAC_SBYTE_BIT))
             == ($past(s_r.cause) & ~$past(s_r.snap_cause)
                 & ~(TAC_CAUSE_W'(1) << TAC_SBYTE_BIT))))
        else $error("clear-on-read left a seen cause bit set");

    chk_sbyte_blip: assert property (@(posedge mclk) disable iff (rst) // see [R3]
        (clr_cause && s_r.snap_cause[TAC_SBYTE_BIT] && sbyte_src && !set_new[TAC_SBYTE_BIT])
        |=> (!s_r.cause[TAC_SBYTE_BIT] ##1 s_r.cause[TAC_SBYTE_BIT]))
        else $error("start-byte cause did not blip low for one cycle");

    chk_sbyte_fixed: assert property (@(posedge mclk) disable iff (rst) // see [R2]
        (clr_cause && s_r.snap_cause[TAC_SBYTE_BIT] && !sbyte_src && !set_all[TAC_SBYTE_BIT])
        |=> (!s_r.cause[TAC_SBYTE_BIT] && !s_r.sbyte_pend))
        else $error("start-byte cause survived a clear after its source was removed");

    chk_count_add: assert property (@(posedge mclk) disable iff (rst) // see [R4]
        (s_r.enable && new_abort) |=>
            (s_r.flush_cnt == TAC_CNT_W'($past(s_r.flush_cnt) + $past(core_ev.tx_fifo_level))))
        else $error("flushed-command count not advanced by the level");

    chk_count_zero: assert property (@(posedge mclk) disable iff (rst) // see [R5]
        !s_r.enable |=> (s_r.flush_cnt == TAC_CNT_RST))
        else $error("flushed-command count not zeroed while disabled");

    chk_sw_abort_bit: assert property (@(posedge mclk) disable iff (rst) // see [R6]
        (s_r.abort_req && core_ev.master_tx) |=>
            (s_r.cause[TAC_SW_ABORT_BIT] && !s_r.abort_req && transmit_abort_event))
        else $error("software abort not recorded in bit 16");

    chk_slvrd_bit: assert property (@(posedge mclk) disable iff (rst) // see [R7]
        (data_cmd_rd && core_ev.slave_rd_req) |=> s_r.cause[TAC_SLVRD_BIT])
        else $error("read command during slave read not recorded in bit 15");

    chk_lost_pair: assert property (@(posedge mclk) disable iff (rst) // see [R8] [R9]
        slv_lost |=> (s_r.cause[TAC_SLV_LOST_BIT] && s_r.cause[TAC_ARBITRATION_LOST_CAUSE_BIT]))
        else $error("slave loss did not set bits 14 and 12 together");

    chk_master_arb: assert property (@(posedge mclk) disable iff (rst) // see [R11]
        core_ev.master_arbitration_lost_cause |=> s_r.cause[TAC_ARBITRATION_LOST_CAUSE_BIT])
        else $error("master arbitration loss not recorded in bit 12");

    chk_stale_flush: assert property (@(posedge mclk) disable iff (rst) // see [R12]
        (core_ev.slave_read_cmd && (core_ev.tx_fifo_level != '0)) |=>
            (s_r.cause[TAC_SLV_FLUSH_BIT] && transmit_abort_event))
        else $error("stale transmit data did not raise bit 13 and an abort");

    chk_no_write: assert property (@(posedge mclk) disable iff (rst) // see [R13]
        (take && avs_req.write && (avs_req.address == TAC_OFF_CAUSE) && !(|set_all)
         && !clr_cause) |=> (s_r.cause == $past(s_r.cause)))
        else $error("write to the cause register changed it");

    chk_irq_level: assert property (@(posedge mclk) disable iff (rst)
        new_abort |=> (irq == s_r.mask[TAC_IRQ_ABORT_BIT]))
        else $error("interrupt level does not follow the mask after an abort");

endmodule

// ==== tb/tac_remote_party.sv ====
// ==========================================================
// Remote bus party: clocks the bus and drives the data line
// ==========================================================
module tac_remote_party (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Frame control from the bench
    input  wire logic run,
    input  wire logic steal,
    input  wire logic tx_bit,
    // Bus lines
    output logic      scl,
    output logic      sda
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph_r;
    // Both lines rest at the pull-up level between frames, and the clock stands still.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst || !run) begin
            ph_r <= 2'h0;
            scl  <= 1'b1;
            sda  <= 1'b1;
        end else begin
            ph_r <= ph_r + 2'h1;
            scl  <= ph_r[1];
            // The data line only moves while the clock line is low.
            if (ph_r == 2'h1) begin
                sda <= steal ? ~tx_bit : tx_bit;
            end
        end
    end
endmodule

// ==== tb/i2c_tx_abort_source_capture_tb.sv ====
module i2c_tx_abort_source_capture_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tac_pkg::*;
    logic          mclk;
    logic          rst;
    tac_avl_req_t  req;
    tac_core_ev_t  core_ev;
    tac_pins_t     pins;
    logic          waitrequest;
    logic [31:0]   readdata;
    logic          abort_evt;
    logic          ctl_en;
    logic          irq;
    logic          run;
    logic          steal;
    logic          tx_bit;
    logic          scl;
    logic          sda;
    logic [31:0]   q;
    int            mismatches;
    int            tests_run;

    always #20 mclk = ~mclk;
    assign pins = '{scl: scl, sda: sda, tx_bit: tx_bit};

    tac_abort_capture i_tac_abort_capture (
        .mclk                 (mclk),
        .rst                  (rst),
        .avs_req              (req),
        .avs_waitrequest      (waitrequest),
        .avs_readdata         (readdata),
        .core_ev              (core_ev),
        .line_pins            (pins),
        .transmit_abort_event (abort_evt),
        .controller_enable    (ctl_en),
        .irq                  (irq)
    );

    tac_remote_party i_tac_remote_party (
        .mclk   (mclk),
        .rst    (rst),
        .run    (run),
        .steal  (steal),
        .tx_bit (tx_bit),
        .scl    (scl),
        .sda    (sda)
    );

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] word(input logic [8:0] cnt, input logic [16:0] bits);
        return {cnt, 6'h00, bits};
    endfunction

    // Entered just after a rising edge; returns just after a rising edge.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req.address   <= a;
        req.writedata <= d;
        req.write     <= wr;
        req.read      <= !wr;
        do begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        req.read  <= 1'b0;
        req.write <= 1'b0;
        if (n >= 50) begin
            chk(32'h1, 32'h0);
        end
        @(posedge mclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask

    // One-hot over read command, arbitration loss and start-byte attempt.
    task automatic pulse(input logic [2:0] m);
        core_ev[7:5] <= m;
        @(posedge mclk);
        core_ev[7:5] <= 3'h0;
        @(posedge mclk);
        chk({31'h0, abort_evt}, 32'h1);
        @(posedge mclk);
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset;
        rd_chk(TAC_OFF_CAUSE, 32'h0000_0000);
        bus(1'b1, TAC_OFF_CAUSE, 32'hffff_ffff);
        rd_chk(TAC_OFF_CAUSE, 32'h0000_0000);
        rd_chk(8'h20, 32'h0000_0000);
        done("reset");
    endtask

    task automatic t_user_abort;
        bus(1'b1, TAC_OFF_IRQ_MASK, 32'h0000_0001);
        bus(1'b1, TAC_OFF_ENABLE, 32'h0000_0001);
        chk({31'h0, ctl_en}, 32'h1);
        core_ev.master_tx      <= 1'b1;
        core_ev.tx_fifo_level  <= 5'h05;
        bus(1'b1, TAC_OFF_ENABLE, 32'h0000_0003);
        repeat (4) @(posedge mclk);
        chk({31'h0, irq}, 32'h1);
        rd_chk(TAC_OFF_CAUSE, word(9'h005, 17'h10000));
        rd_chk(TAC_OFF_IRQ_STAT, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0);
        core_ev.master_tx <= 1'b0;
        rd_chk(TAC_OFF_CLR_ABORT, 32'h0000_0000);
        rd_chk(TAC_OFF_CAUSE, word(9'h005, 17'h0));
        done("user_abort");
    endtask

    task automatic t_slave_events;
        core_ev.slave_rd_req  <= 1'b1;
        core_ev.tx_fifo_level <= 5'h03;
        bus(1'b1, TAC_OFF_DATA_CMD, 32'h0000_0100);
        rd_chk(TAC_OFF_CAUSE, word(9'h008, 17'h08000));
        core_ev.slave_rd_req  <= 1'b0;
        core_ev.tx_fifo_level <= 5'h02;
        pulse(3'h4);
        rd_chk(TAC_OFF_CAUSE, word(9'h00a, 17'h0a000));
        rd_chk(TAC_OFF_CLR_ALL, 32'h0000_0000);
        rd_chk(TAC_OFF_CAUSE, word(9'h00a, 17'h0));
        done("slave_events");
    endtask

    task automatic t_loss;
        core_ev.tx_fifo_level <= 5'h00;
        core_ev.slave_tx      <= 1'b1;
        tx_bit <= 1'b1;
        run    <= 1'b1;
        repeat (12) @(posedge mclk);
        rd_chk(TAC_OFF_CAUSE, word(9'h00a, 17'h0));
        steal <= 1'b1;
        repeat (8) @(posedge mclk);
        run   <= 1'b0;
        steal <= 1'b0;
        rd_chk(TAC_OFF_CAUSE, word(9'h00a, 17'h05000));
        core_ev.slave_tx <= 1'b0;
        rd_chk(TAC_OFF_CLR_ABORT, 32'h0000_0000);
        bus(1'b1, TAC_OFF_IRQ_MASK, 32'h0000_0000);
        core_ev.tx_fifo_level <= 5'h01;
        pulse(3'h2);
        chk({31'h0, irq}, 32'h0);
        rd_chk(TAC_OFF_CAUSE, word(9'h00b, 17'h01000));
        rd_chk(TAC_OFF_IRQ_STAT, 32'h0000_0001);
        done("loss");
    endtask

    task automatic t_sbyte;
        rd_chk(TAC_OFF_CLR_ABORT, 32'h0000_0000);
        core_ev.tx_fifo_level <= 5'h00;
        bus(1'b1, TAC_OFF_CONFIG, 32'h0000_0000);
        bus(1'b1, TAC_OFF_TARGET, 32'h0000_0c00);
        pulse(3'h1);
        rd_chk(TAC_OFF_CAUSE, word(9'h00b, 17'h00200));
        rd_chk(TAC_OFF_CLR_ABORT, 32'h0000_0000);
        rd_chk(TAC_OFF_CAUSE, word(9'h00b, 17'h00200));
        bus(1'b1, TAC_OFF_CONFIG, 32'h0000_0020);
        rd_chk(TAC_OFF_CLR_ABORT, 32'h0000_0000);
        rd_chk(TAC_OFF_CAUSE, word(9'h00b, 17'h0));
        done("start_byte");
    endtask

    task automatic t_disable;
        bus(1'b1, TAC_OFF_ENABLE, 32'h0000_0000);
        chk({31'h0, ctl_en}, 32'h0);
        rd_chk(TAC_OFF_CAUSE, 32'h0000_0000);
        done("disable");
    endtask

    // ==========================================================
    // Main sequence and watchdog
    // ==========================================================
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        req = '0;
        core_ev = '0;
        run = 1'b0;
        steal = 1'b0;
        tx_bit = 1'b1;
        mismatches = 0;
        tests_run = 0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_user_abort();
        t_slave_events();
        t_loss();
        t_sbyte();
        t_disable();
        print_verdict();
    end

    // The full run needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge mclk);
        mismatches++;
        print_verdict();
    end
endmodule
